// file: verilog/acg_consts.svh
// register offsets, field positions, reset values and clock ratios for the audio clock control block
`ifndef ACG_CONSTS_SVH
`define ACG_CONSTS_SVH
`define ACG_OFS_RATE_SEL 16'he220
`define ACG_OFS_GATE_EN 16'he280
`define ACG_RATE_SEL_RESET 16'h0000
`define ACG_GATE_EN_RESET 16'h0000
`define ACG_RATE_SEL_MSB 4
`define ACG_GATE_EN_MSB 8
`define ACG_SRC_SER_IN_FIRST 5'h03
`define ACG_SRC_SER_IN_LAST 5'h0e
`define ACG_SRC_SER_OUT_FIRST 5'h0f
`define ACG_SRC_SER_OUT_LAST 5'h1a
`define ACG_GATE_AUX_CONV 8
`define ACG_GATE_SPDIF_TX 7
`define ACG_GATE_SPDIF_RX 6
`define ACG_GATE_CORE 5
`define ACG_GATE_SRC_HI 4
`define ACG_GATE_SRC_LO 3
`define ACG_GATE_SER_OUT 2
`define ACG_GATE_SER_IN 1
`define ACG_GATE_ROUTING 0
`define ACG_CORE_PER_BASE 3584
`define ACG_CORE_PER_DOUBLE 1792
`define ACG_CORE_PER_QUAD 896
`define ACG_OUT_MULT_LOW 256
`define ACG_OUT_MULT_HIGH 512
`endif

// file: verilog/acg_pkg.sv
// types shared by the audio clock control block
package acg_pkg;
   typedef enum logic [1:0] {
      ACG_OUT_OFF = 2'h0,
      ACG_OUT_OSC = 2'h1,
      ACG_OUT_X256 = 2'h2,
      ACG_OUT_X512 = 2'h3
   } acg_out_mode_type;
   typedef enum logic [4:0] {
      ACG_SRC_BASE = 5'h00,
      ACG_SRC_DOUBLE = 5'h01,
      ACG_SRC_QUAD = 5'h02,
      ACG_SRC_SPDIF = 5'h1b
   } acg_src_fixed_type;
endpackage : acg_pkg

// file: verilog/acg_rate_div.sv
// divides the core clock into one-cycle sample pulses at base, double and quad rate
`include "acg_consts.svh"
module acg_rate_div #(
   parameter int PERIOD = `ACG_CORE_PER_BASE
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic run,
   output logic base_pulse,
   output logic double_pulse,
   output logic quad_pulse
);
   import acg_pkg::*;
   localparam int QUARTER = PERIOD / 4;
   logic [11:0] count_reg;
   logic quarter_hit;

   assign quarter_hit = (count_reg == 12'(QUARTER - 1)) || (count_reg == 12'(2 * QUARTER - 1))
      || (count_reg == 12'(3 * QUARTER - 1)) || (count_reg == 12'(PERIOD - 1));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 12'h000;
      end else if (clk_en) begin
         if (!run || count_reg == 12'(PERIOD - 1)) begin
            count_reg <= 12'h000;
         end else begin
            count_reg <= count_reg + 12'h001;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         base_pulse <= 1'b0;
         double_pulse <= 1'b0;
         quad_pulse <= 1'b0;
      end else if (clk_en) begin
         base_pulse <= run && count_reg == 12'(PERIOD - 1);
         double_pulse <= run && (count_reg == 12'(2 * QUARTER - 1) || count_reg == 12'(PERIOD - 1));
         quad_pulse <= run && quarter_hit;
      end
   end
endmodule : acg_rate_div

// file: verilog/acg_pulse_sel.sv
// synchronises the external frame clocks and picks the start pulse source
`include "acg_consts.svh"
module acg_pulse_sel #(
   parameter int PAIRS = 12
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [4:0] source_sel,
   input wire logic base_pulse,
   input wire logic double_pulse,
   input wire logic quad_pulse,
   input wire logic [PAIRS-1:0] ser_in_frame_clk,
   input wire logic [PAIRS-1:0] ser_out_frame_clk,
   input wire logic spdif_frame_clk,
   output logic start_pulse
);
   import acg_pkg::*;
   localparam int NSRC = 2 * PAIRS + 1;
   logic [NSRC-1:0] ext_meta_reg;
   logic [NSRC-1:0] ext_sync_reg;
   logic [NSRC-1:0] ext_last_reg;
   logic [NSRC-1:0] ext_rise;
   logic pick;

   // frame clocks come from pins: two flops, then edge detect on the second
   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_sync
         logic raw;
         if (g < PAIRS) begin : g_in
            assign raw = ser_in_frame_clk[g];
         end else if (g < 2 * PAIRS) begin : g_out
            assign raw = ser_out_frame_clk[g-PAIRS];
         end else begin : g_sp
            assign raw = spdif_frame_clk;
         end
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               ext_meta_reg[g] <= 1'b0;
               ext_sync_reg[g] <= 1'b0;
               ext_last_reg[g] <= 1'b0;
            end else if (clk_en) begin
               ext_meta_reg[g] <= raw;
               ext_sync_reg[g] <= ext_meta_reg[g];
               ext_last_reg[g] <= ext_sync_reg[g];
            end
         end
         assign ext_rise[g] = ext_sync_reg[g] & ~ext_last_reg[g];
      end
   endgenerate

   always_comb begin
      pick = 1'b0;
      if (source_sel == ACG_SRC_BASE) begin
         pick = base_pulse;
      end else if (source_sel == ACG_SRC_DOUBLE) begin
         pick = double_pulse;
      end else if (source_sel == ACG_SRC_QUAD) begin
         pick = quad_pulse;
      end else if (source_sel >= `ACG_SRC_SER_IN_FIRST && source_sel <= `ACG_SRC_SER_IN_LAST) begin
         pick = ext_rise[5'(source_sel - `ACG_SRC_SER_IN_FIRST)];
      end else if (source_sel >= `ACG_SRC_SER_OUT_FIRST && source_sel <= `ACG_SRC_SER_OUT_LAST) begin
         pick = ext_rise[5'(source_sel - `ACG_SRC_SER_OUT_FIRST) + 5'(PAIRS)];
      end else if (source_sel == ACG_SRC_SPDIF) begin
         pick = ext_rise[NSRC-1];
      end
      // codes above the receiver code fall through: the core gets no pulse
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_pulse <= 1'b0;
      end else if (clk_en) begin
         start_pulse <= pick;
      end
   end
endmodule : acg_pulse_sel

// file: verilog/acg_clock_ctrl.sv
// audio clock control: clock output select, core start pulse select and subsystem clock gates
// Functional notes
// - clock output set by select straps latched once after reset: off, oscillator copy, 256x or 512x base rate
// - start pulse launches each core pass and sets the core sample rate
// - source field resets to base rate; 1 picks double, 2 picks quad rate
// - codes 3 to 14 pick serial input frame clocks of pairs 0 to 11
// - codes 15 to 26 pick serial output frame clocks of pairs 0 to 11
// - code 27 picks the receiver's recovered frame clock
// - codes 28 to 31 give no start pulse; core stays idle
// - core clock is 3584 base periods; double gives 1792, quad 896 per sample
// - each enable bit gates one subsystem clock; all reset to zero
// - enable bit map: 8 aux, 7 tx, 6 rx, 5 core, 4/3 converters, 2/1 serial, 0 routing
`include "acg_consts.svh"
module acg_clock_ctrl #(
   parameter int PAIRS = 12,
   parameter int CORE_PERIOD = `ACG_CORE_PER_BASE
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic clock_output_select_hi,
   input wire logic clock_output_select_lo,
   input wire logic osc_clk_in,
   input wire logic x256_clk_in,
   input wire logic x512_clk_in,
   input wire logic [PAIRS-1:0] ser_in_frame_clk,
   input wire logic [PAIRS-1:0] ser_out_frame_clk,
   input wire logic spdif_frame_clk,
   output logic clock_output_pin,
   output logic clock_output_pin_oe,
   output logic core_start_pulse,
   output logic [8:0] subsystem_clk_en,
   output logic [1:0] clock_output_mode
);
   import acg_pkg::*;
   logic rst_meta_reg;
   logic rst_sync_n;
   logic [1:0] strap_meta_reg;
   logic [1:0] strap_sync_reg;
   logic [2:0] clk_meta_reg;
   logic [2:0] clk_sync_reg;
   logic [`ACG_RATE_SEL_MSB:0] rate_sel_reg;
   logic [`ACG_GATE_EN_MSB:0] gate_en_reg;
   logic [1:0] out_mode_reg;
   logic strap_taken_reg;
   logic [1:0] strap_fill_reg;
   logic base_pulse;
   logic double_pulse;
   logic quad_pulse;
   logic core_run;

   // reset released through two flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n <= rst_meta_reg;
      end
   end

   // strap pins and the reference clocks are asynchronous: two flops each
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         strap_meta_reg <= 2'h0;
         strap_sync_reg <= 2'h0;
         clk_meta_reg <= 3'h0;
         clk_sync_reg <= 3'h0;
      end else if (clk_en) begin
         strap_meta_reg <= {clock_output_select_hi, clock_output_select_lo};
         strap_sync_reg <= strap_meta_reg;
         clk_meta_reg <= {x512_clk_in, x256_clk_in, osc_clk_in};
         clk_sync_reg <= clk_meta_reg;
      end
   end

   // straps latched once, only after the two-flop copy has filled; taking it earlier would always latch off
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         out_mode_reg <= ACG_OUT_OFF;
         strap_fill_reg <= 2'h0;
         strap_taken_reg <= 1'b0;
      end else if (clk_en) begin
         strap_fill_reg <= {strap_fill_reg[0], 1'b1};
         if (strap_fill_reg[1] && !strap_taken_reg) begin
            out_mode_reg <= strap_sync_reg;
            strap_taken_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         clock_output_pin <= 1'b0;
         clock_output_pin_oe <= 1'b0;
      end else if (clk_en) begin
         unique case (out_mode_reg)
            ACG_OUT_OFF: begin
               clock_output_pin <= 1'b0;
               clock_output_pin_oe <= 1'b0;
            end
            ACG_OUT_OSC: begin
               clock_output_pin <= clk_sync_reg[0];
               clock_output_pin_oe <= 1'b1;
            end
            ACG_OUT_X256: begin
               clock_output_pin <= clk_sync_reg[1];
               clock_output_pin_oe <= 1'b1;
            end
            ACG_OUT_X512: begin
               clock_output_pin <= clk_sync_reg[2];
               clock_output_pin_oe <= 1'b1;
            end
         endcase
      end
   end

   assign clock_output_mode = out_mode_reg;

   // register writes; reserved bits are not stored
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rate_sel_reg <= 5'(`ACG_RATE_SEL_RESET);
      end else if (clk_en && reg_wr && reg_addr == `ACG_OFS_RATE_SEL) begin
         rate_sel_reg <= reg_wdata[`ACG_RATE_SEL_MSB:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         gate_en_reg <= 9'(`ACG_GATE_EN_RESET);
      end else if (clk_en && reg_wr && reg_addr == `ACG_OFS_GATE_EN) begin
         gate_en_reg <= reg_wdata[`ACG_GATE_EN_MSB:0];
      end
   end

   // read data registered one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else if (clk_en) begin
         reg_rvalid <= reg_rd;
         if (reg_rd && reg_addr == `ACG_OFS_RATE_SEL) begin
            reg_rdata <= {11'h000, rate_sel_reg};
         end else if (reg_rd && reg_addr == `ACG_OFS_GATE_EN) begin
            reg_rdata <= {7'h00, gate_en_reg};
         end else begin
            reg_rdata <= 16'h0000;
         end
      end
   end

   // gate outputs come straight from the enable flops, bit for bit
   assign subsystem_clk_en = gate_en_reg;

   // dividers only run while the core clock is passed, saving power otherwise
   assign core_run = gate_en_reg[`ACG_GATE_CORE];

   acg_rate_div #(
      .PERIOD(CORE_PERIOD)
   ) u_div (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .clk_en(clk_en),
      .run(core_run),
      .base_pulse(base_pulse),
      .double_pulse(double_pulse),
      .quad_pulse(quad_pulse)
   );

   acg_pulse_sel #(
      .PAIRS(PAIRS)
   ) u_sel (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .clk_en(clk_en),
      .source_sel(rate_sel_reg),
      .base_pulse(base_pulse),
      .double_pulse(double_pulse),
      .quad_pulse(quad_pulse),
      .ser_in_frame_clk(ser_in_frame_clk),
      .ser_out_frame_clk(ser_out_frame_clk),
      .spdif_frame_clk(spdif_frame_clk),
      .start_pulse(core_start_pulse)
   );
endmodule : acg_clock_ctrl

// file: tb/acg_clock_ctrl_sva.sv
// port assertions for the audio clock control block
`include "acg_consts.svh"
module acg_clock_ctrl_sva #(
   parameter int CORE_PERIOD = `ACG_CORE_PER_BASE
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic osc_clk_in,
   input wire logic x256_clk_in,
   input wire logic x512_clk_in,
   input wire logic clock_output_pin,
   input wire logic clock_output_pin_oe,
   input wire logic core_start_pulse,
   input wire logic [8:0] subsystem_clk_en,
   input wire logic [1:0] clock_output_mode
);
   logic [4:0] sel_q;
   logic [3:0] since;
   logic seen;
   logic ref_clk;
   int gap;
   assign ref_clk = clock_output_mode == 2'h1 ? osc_clk_in : (clock_output_mode == 2'h2 ? x256_clk_in : x512_clk_in);
   // shadow of the rate field; pulses still in flight just after a write are not judged
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= 5'h00;
         since <= 4'h0;
         seen <= 1'b0;
         gap <= 0;
      end else begin
         gap <= core_start_pulse ? 1 : gap + 1;
         if (since != 4'hf) since <= since + 4'h1;
         if (core_start_pulse && since > 4'h6) seen <= 1'b1;
         if (reg_wr && clk_en) begin
            since <= 4'h0;
            seen <= 1'b0;
            if (reg_addr == `ACG_OFS_RATE_SEL) sel_q <= reg_wdata[4:0];
         end
      end
   end
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   AST_OUT_OFF: assert property (clock_output_mode == 2'h0 |-> !clock_output_pin_oe && !clock_output_pin)
      else $error("clock output active while off");
   AST_OUT_OE: assert property (clock_output_mode != 2'h0 |=> clock_output_pin_oe)
      else $error("clock output not driven");
   AST_PIN_FOLLOW: assert property ((clock_output_mode != 2'h0 && $stable(ref_clk))[*6]
      |-> clock_output_pin == ref_clk)
      else $error("clock output does not follow reference");
   AST_PULSE_ONE: assert property (core_start_pulse |=> !core_start_pulse)
      else $error("start pulse longer than one cycle");
   AST_NO_PULSE_OFF: assert property (sel_q[4:2] == 3'h7 && since > 4'h6 |-> !core_start_pulse)
      else $error("start pulse with core disabled");
   AST_GATED_CORE: assert property (sel_q < 5'h03 && !subsystem_clk_en[5] && since > 4'h6
      |-> !core_start_pulse)
      else $error("internal pulse with core clock gated");
   AST_RATE_GAP: assert property (core_start_pulse && seen && sel_q < 5'h03
      |-> gap == (CORE_PERIOD >> sel_q))
      else $error("internal start pulse spacing wrong");
   AST_RVALID: assert property (reg_rd && clk_en |=> reg_rvalid)
      else $error("read not answered");
   AST_RSVD_ZERO: assert property (reg_rvalid |-> reg_rdata[15:9] == 7'h00)
      else $error("reserved bits read nonzero");
   AST_GATE_WR: assert property (reg_wr && clk_en && reg_addr == `ACG_OFS_GATE_EN
      |=> subsystem_clk_en == $past(reg_wdata[8:0]))
      else $error("gate enables do not follow write");
   AST_RATE_RD: assert property (reg_rd && clk_en && reg_addr == `ACG_OFS_RATE_SEL
      |=> reg_rdata == {11'h000, $past(sel_q)})
      else $error("rate field readback wrong");
   AST_FREEZE: assert property (!clk_en |=> $stable(subsystem_clk_en) && $stable(reg_rdata)
      && $stable(reg_rvalid) && $stable(core_start_pulse))
      else $error("state moved while clock enable low");
endmodule : acg_clock_ctrl_sva
bind acg_clock_ctrl acg_clock_ctrl_sva #(.CORE_PERIOD(CORE_PERIOD)) u_sva (.*);

// file: tb/acg_clk_sink.sv
// far-side chip that counts the rising master clock edges it receives
module acg_clk_sink (
   input wire logic clock_output_pin,
   input wire logic clock_output_pin_oe,
   output int edges
);
   timeunit 1ns;
   timeprecision 1ns;
   logic line;
   // an undriven line is pulled low at the receiver
   assign line = clock_output_pin_oe ? clock_output_pin : 1'b0;
   initial edges = 0;
   always @(posedge line) edges = edges + 1;
endmodule : acg_clk_sink

// file: tb/audio_dsp_clock_select_gating_bench.sv
// self-checking bench for the audio clock control block
`include "acg_consts.svh"
module audio_dsp_clock_select_gating_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int P = 16;
   typedef struct {logic [15:0] a; logic [15:0] d; logic [15:0] q;} acg_row_type;
   // gate register written first after reset, as software must
   acg_row_type rows [7] = '{'{16'he280, 16'hffff, 16'h01ff}, '{16'he220, 16'hffe5, 16'h0005},
      '{16'he220, 16'h001f, 16'h001f}, '{16'he224, 16'h1234, 16'h0000}, '{16'he280, 16'h0155, 16'h0155},
      '{16'he280, 16'h00aa, 16'h00aa}, '{16'he220, 16'h0000, 16'h0000}};
   logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, q;
   logic reg_rvalid, pin, pin_oe, pulse;
   logic [1:0] strap = 2'h1, mode;
   logic [5:0] cyc = 6'h00;
   logic [24:0] fc = 25'h0000000;
   logic [8:0] gate;
   int mismatches = 0, tests_run = 0, edges, n, c;
   always #50 core_clk = ~core_clk;
   // references with 8, 16 and 32 cycle half periods, slow enough to resample
   always @(negedge core_clk) cyc <= cyc + 6'h01;
   acg_clock_ctrl #(.PAIRS(12), .CORE_PERIOD(P)) dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .clock_output_select_hi(strap[1]), .clock_output_select_lo(strap[0]),
      .osc_clk_in(cyc[3]), .x256_clk_in(cyc[4]), .x512_clk_in(cyc[5]), .ser_in_frame_clk(fc[11:0]),
      .ser_out_frame_clk(fc[23:12]), .spdif_frame_clk(fc[24]), .clock_output_pin(pin),
      .clock_output_pin_oe(pin_oe), .core_start_pulse(pulse), .subsystem_clk_en(gate), .clock_output_mode(mode));
   acg_clk_sink sink (.clock_output_pin(pin), .clock_output_pin_oe(pin_oe), .edges(edges));
   task automatic close_out;
      if (mismatches == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(negedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(negedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(negedge core_clk);
      // rvalid stands only in the cycle after the strobe edge
      d = reg_rvalid === 1'b1 ? reg_rdata : 16'hdead;
      reg_rd <= 1'b0;
   endtask : rd
   task automatic wait_pulse(input int lim);
      c = 0;
      while (pulse !== 1'b1 && c < lim) begin
         @(negedge core_clk);
         c++;
      end
   endtask : wait_pulse
   task automatic reset_check(input logic [1:0] s);
      @(negedge core_clk);
      rst_n <= 1'b0;
      strap <= s;
      repeat (20) @(negedge core_clk);
      rst_n <= 1'b1;
      repeat (5) @(negedge core_clk);
      chk({14'h0000, mode}, {14'h0000, s});
      rd(`ACG_OFS_RATE_SEL, q);
      chk(q, `ACG_RATE_SEL_RESET);
      rd(`ACG_OFS_GATE_EN, q);
      chk(q, `ACG_GATE_EN_RESET);
      n = edges;
      repeat (80) @(negedge core_clk);
      chk(16'(edges > n), 16'(s != 2'h0));
   endtask : reset_check
   initial begin
      #1000000;
      mismatches++;
      close_out;
   end
   initial begin
      reset_check(2'h1);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, q);
         chk(q, rows[i].q);
         if (rows[i].a == `ACG_OFS_GATE_EN) chk({7'h00, gate}, rows[i].q);
      end
      for (int k = 0; k < 3; k++) begin
         wr(`ACG_OFS_RATE_SEL, 16'(k));
         repeat (P) @(negedge core_clk);
         wait_pulse(3 * P);
         @(negedge core_clk);
         wait_pulse(2 * P);
         chk(16'(c + 1), 16'(P >> k));
      end
      wr(`ACG_OFS_GATE_EN, 16'h01df);
      repeat (8) @(negedge core_clk);
      wait_pulse(3 * P);
      chk(16'(c), 16'(3 * P));
      wr(`ACG_OFS_GATE_EN, 16'h01ff);
      for (int k = 3; k < 32; k++) begin
         wr(`ACG_OFS_RATE_SEL, 16'(k));
         repeat (8) @(negedge core_clk);
         // every other frame clock rises first, so a wrong pick shows as an early pulse
         fc <= k < 28 ? ~(25'h0000001 << (k - 3)) : '1;
         wait_pulse(10);
         chk(16'(c), 16'h000a);
         if (k < 28) begin
            fc <= '1;
            wait_pulse(10);
            chk(16'(c < 10), 16'h0001);
         end
         @(negedge core_clk);
         fc <= '0;
         repeat (4) @(negedge core_clk);
      end
      // a write while the enable is low must not land
      clk_en <= 1'b0;
      wr(`ACG_OFS_GATE_EN, 16'h0000);
      clk_en <= 1'b1;
      rd(`ACG_OFS_GATE_EN, q);
      chk(q, 16'h01ff);
      for (int s = 0; s < 4; s++) reset_check(2'(s));
      close_out;
   end
endmodule : audio_dsp_clock_select_gating_bench
